/* core/gate_output_stage.v */
`default_nettype none
`include "ocp_defs.vh"

// ==========================================================================
// registered six-gate output stage: pwm value or forced protection level
module gate_output_stage (
	input  wire                    clk_sys_i,
	input  wire                    rst_b_i,
	input  wire                    ce_i,
	input  wire                    force_i,
	input  wire [`OCP_LVL_W-1:0]   pwm_gate_i,
	input  wire [`OCP_LVL_W-1:0]   level_i,
	output reg  [`OCP_LVL_W-1:0]   gate_o
);

	// gates start low so the bridge is off until the first pwm value lands
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gate_o <= {`OCP_LVL_W{1'b0}};
		end else if (ce_i) begin
			gate_o <= force_i ? level_i : pwm_gate_i; // R10
		end
	end

endmodule // gate_output_stage

`default_nettype wire

/* core/level_sync.v */
`default_nettype none

// ==========================================================================
// two flip-flop synchroniser for an asynchronous level
module level_sync (
	input  wire clk_sys_i,
	input  wire rst_b_i,
	input  wire ce_i,
	input  wire async_i,
	output reg  sync_o
);

	reg meta;

	// first stage is read only by the second stage
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta   <= 1'b0;
			sync_o <= 1'b0;
		end else if (ce_i) begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end

endmodule // level_sync

`default_nettype wire

/* core/ocp_defs.vh */
`ifndef OCP_DEFS_VH
`define OCP_DEFS_VH

// ==========================================================================
// register offsets (4-bit register port address)
`define OCP_ADDR_W            4
`define OCP_DATA_W            8
`define OCP_OFS_CONTROL       4'h0
`define OCP_OFS_LEVEL_SEL     4'h1
`define OCP_OFS_STATUS        4'h2
`define OCP_OFS_TRIP_COUNT    4'h3
`define OCP_OFS_CUT_PERIODS   4'h4

// ==========================================================================
// protect_control fields
`define OCP_CTL_SW_REQUEST    0
`define OCP_CTL_SW_PAUSE_SEL  4
`define OCP_CTL_CBC_ENABLE    6
`define OCP_CTL_RESET         8'h00

// ==========================================================================
// gate_protect_level_select fields (phase a high side in bit 0)
`define OCP_LVL_A_HIGH        0
`define OCP_LVL_A_LOW         1
`define OCP_LVL_B_HIGH        2
`define OCP_LVL_B_LOW         3
`define OCP_LVL_C_HIGH        4
`define OCP_LVL_C_LOW         5
`define OCP_LVL_W             6
`define OCP_LVL_RESET         6'h00

// ==========================================================================
// protect_status fields
`define OCP_STS_FORCED        0
`define OCP_STS_CBC_CUT       1
`define OCP_STS_FAULT         2
`define OCP_STS_TRIP_NOW      3
`define OCP_STS_TRIP_SEEN     4
`define OCP_STS_FAULT_SEEN    5
`define OCP_CNT_RESET         8'h00
`define OCP_CNT_MAX           8'hff

`endif

/* core/pwm_overcurrent_protection.v */
// Decided for this implementation: the address-and-strobe port and the address map.
`default_nettype none
`include "ocp_defs.vh"

// Overview of operation
// R1 - control bit 6 enables cycle-by-cycle over current protection; resets to zero
// R2 - with cycle-by-cycle active, a current trip switches the pwm outputs off
// R3 - after a cycle-by-cycle cut, outputs return at the next pwm period start
// R4 - if the trip persists at restore, outputs go off again at once
// R5 - control bit 4 picks software protection mode: zero fault, one pause
// R6 - phase c low and high gate protected levels, zero low, one high
// R7 - phase b low and high gate protected levels, zero low, one high
// R8 - phase a low and high gate protected levels, zero low, one high
// R9 - level register bits 7 and 6 read zero; all bits reset to zero
// R10 - while protection holds, each gate takes its own selected level
module pwm_overcurrent_protection (
	input  wire                     clk_sys_i,
	input  wire                     rst_b_i,
	input  wire                     ce_i,
	// register port
	input  wire [`OCP_ADDR_W-1:0]   reg_addr_i,
	input  wire [`OCP_DATA_W-1:0]   reg_wdata_i,
	input  wire                     reg_wr_i,
	input  wire                     reg_rd_i,
	output reg  [`OCP_DATA_W-1:0]   reg_rdata_o,
	// pwm generator, same clock
	input  wire                     pwm_period_start_i,
	input  wire                     phase_a_high_pwm_i,
	input  wire                     phase_a_low_pwm_i,
	input  wire                     phase_b_high_pwm_i,
	input  wire                     phase_b_low_pwm_i,
	input  wire                     phase_c_high_pwm_i,
	input  wire                     phase_c_low_pwm_i,
	// current-sense comparator pin, asynchronous
	input  wire                     current_sense_trip_i,
	// gate driver pins
	output wire                     phase_a_high_gate_o,
	output wire                     phase_a_low_gate_o,
	output wire                     phase_b_high_gate_o,
	output wire                     phase_b_low_gate_o,
	output wire                     phase_c_high_gate_o,
	output wire                     phase_c_low_gate_o,
	output reg                      outputs_forced_o
);

	// ======================================================================
	// functions

	// saturating increment, shared by both event counters
	function [`OCP_DATA_W-1:0] sat_inc;
		input [`OCP_DATA_W-1:0] value;
		begin
			if (value == `OCP_CNT_MAX)
				sat_inc = value;
			else
				sat_inc = value + 8'h01;
		end
	endfunction

	// ======================================================================
	// declarations

	reg                       cycle_by_cycle_enable;
	reg                       sw_pause_fault_select;
	reg                       sw_protect_request;
	reg                       sw_request_d;
	reg  [`OCP_LVL_W-1:0]     gate_protect_level_select;
	reg                       cbc_cut;
	reg                       fault_latched;
	reg                       trip_seen;
	reg                       fault_seen;
	reg                       trip_d;
	reg  [`OCP_DATA_W-1:0]    trip_count;
	reg  [`OCP_DATA_W-1:0]    cut_periods;
	reg  [`OCP_DATA_W-1:0]    next_rdata;
	reg                       next_cbc_cut;

	wire                      trip_sync;
	wire                      wr_control;
	wire                      wr_level;
	wire                      wr_status;
	wire                      wr_trip_count;
	wire                      wr_cut_periods;
	wire                      trip_rise;
	wire                      sw_request_rise;
	wire                      sw_pause_active;
	wire                      force_gates;
	wire [`OCP_LVL_W-1:0]     pwm_gate;
	wire [`OCP_LVL_W-1:0]     gate_bus;
	wire [`OCP_DATA_W-1:0]    status_word;

	// ======================================================================
	// comparator input crossing

	// the comparator is asynchronous to the pwm clock; two stages cost
	// two cycles of reaction time but keep metastability off the gates
	level_sync u_trip_sync (
		.clk_sys_i (clk_sys_i),
		.rst_b_i   (rst_b_i),
		.ce_i      (ce_i),
		.async_i   (current_sense_trip_i),
		.sync_o    (trip_sync)
	);

	// ======================================================================
	// register write decode

	assign wr_control     = reg_wr_i && (reg_addr_i == `OCP_OFS_CONTROL);
	assign wr_level       = reg_wr_i && (reg_addr_i == `OCP_OFS_LEVEL_SEL);
	assign wr_status      = reg_wr_i && (reg_addr_i == `OCP_OFS_STATUS);
	assign wr_trip_count  = reg_wr_i && (reg_addr_i == `OCP_OFS_TRIP_COUNT);
	assign wr_cut_periods = reg_wr_i && (reg_addr_i == `OCP_OFS_CUT_PERIODS);

	// control register: mode bits and software request
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cycle_by_cycle_enable <= 1'b0; // R1
			sw_pause_fault_select <= 1'b0;
			sw_protect_request    <= 1'b0;
		end else if (ce_i && wr_control) begin
			cycle_by_cycle_enable <= reg_wdata_i[`OCP_CTL_CBC_ENABLE]; // R1
			sw_pause_fault_select <= reg_wdata_i[`OCP_CTL_SW_PAUSE_SEL]; // R5
			sw_protect_request    <= reg_wdata_i[`OCP_CTL_SW_REQUEST];
		end
	end

	// protected level for each gate; upper two bits are not stored
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gate_protect_level_select <= `OCP_LVL_RESET; // R9
		end else if (ce_i && wr_level) begin
			gate_protect_level_select[`OCP_LVL_C_LOW]  <= reg_wdata_i[`OCP_LVL_C_LOW]; // R6
			gate_protect_level_select[`OCP_LVL_C_HIGH] <= reg_wdata_i[`OCP_LVL_C_HIGH]; // R6
			gate_protect_level_select[`OCP_LVL_B_LOW]  <= reg_wdata_i[`OCP_LVL_B_LOW]; // R7
			gate_protect_level_select[`OCP_LVL_B_HIGH] <= reg_wdata_i[`OCP_LVL_B_HIGH]; // R7
			gate_protect_level_select[`OCP_LVL_A_LOW]  <= reg_wdata_i[`OCP_LVL_A_LOW]; // R8
			gate_protect_level_select[`OCP_LVL_A_HIGH] <= reg_wdata_i[`OCP_LVL_A_HIGH]; // R8
		end
	end

	// ======================================================================
	// cycle-by-cycle protection

	// a period start restores the outputs only if the trip has gone;
	// a trip still present at that edge keeps the cut with no gap
	always @* begin
		next_cbc_cut = cbc_cut;
		if (!cycle_by_cycle_enable) begin
			next_cbc_cut = 1'b0; // R1
		end else if (trip_sync) begin
			next_cbc_cut = 1'b1; // R2 R4
		end else if (pwm_period_start_i) begin
			next_cbc_cut = 1'b0; // R3
		end
	end

	// cut flag register
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cbc_cut <= 1'b0;
		end else if (ce_i) begin
			cbc_cut <= next_cbc_cut;
		end
	end

	// ======================================================================
	// software-triggered protection

	assign sw_request_rise = sw_protect_request && !sw_request_d;

	// pause mode follows the request bit; fault mode latches on it
	assign sw_pause_active = sw_protect_request && sw_pause_fault_select; // R5

	// fault latch: set by a request edge in fault mode, released by
	// writing one to its status bit; a set in the same cycle wins
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sw_request_d  <= 1'b0;
			fault_latched <= 1'b0;
		end else if (ce_i) begin
			sw_request_d <= sw_protect_request;
			if (sw_request_rise && !sw_pause_fault_select) begin
				fault_latched <= 1'b1; // R5
			end else if (wr_status && reg_wdata_i[`OCP_STS_FAULT]) begin
				fault_latched <= 1'b0;
			end
		end
	end

	// ======================================================================
	// event flags and counters

	assign trip_rise = trip_sync && !trip_d;

	// sticky flags clear on write one; a new event beats the clear
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			trip_d     <= 1'b0;
			trip_seen  <= 1'b0;
			fault_seen <= 1'b0;
		end else if (ce_i) begin
			trip_d <= trip_sync;
			if (trip_rise) begin
				trip_seen <= 1'b1;
			end else if (wr_status && reg_wdata_i[`OCP_STS_TRIP_SEEN]) begin
				trip_seen <= 1'b0;
			end
			if (sw_request_rise && !sw_pause_fault_select) begin
				fault_seen <= 1'b1;
			end else if (wr_status && reg_wdata_i[`OCP_STS_FAULT_SEEN]) begin
				fault_seen <= 1'b0;
			end
		end
	end

	// counters saturate rather than wrap so a flood of trips stays visible
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			trip_count  <= `OCP_CNT_RESET;
			cut_periods <= `OCP_CNT_RESET;
		end else if (ce_i) begin
			if (trip_rise) begin
				trip_count <= sat_inc(trip_count);
			end else if (wr_trip_count) begin
				trip_count <= `OCP_CNT_RESET;
			end
			if (pwm_period_start_i && cbc_cut && next_cbc_cut) begin
				cut_periods <= sat_inc(cut_periods);
			end else if (wr_cut_periods) begin
				cut_periods <= `OCP_CNT_RESET;
			end
		end
	end

	// ======================================================================
	// gate forcing

	// every protection source forces the same per-gate levels
	assign force_gates = cbc_cut || fault_latched || sw_pause_active; // R10

	assign pwm_gate[`OCP_LVL_A_HIGH] = phase_a_high_pwm_i;
	assign pwm_gate[`OCP_LVL_A_LOW]  = phase_a_low_pwm_i;
	assign pwm_gate[`OCP_LVL_B_HIGH] = phase_b_high_pwm_i;
	assign pwm_gate[`OCP_LVL_B_LOW]  = phase_b_low_pwm_i;
	assign pwm_gate[`OCP_LVL_C_HIGH] = phase_c_high_pwm_i;
	assign pwm_gate[`OCP_LVL_C_LOW]  = phase_c_low_pwm_i;

	// gate pins are registered inside the stage
	gate_output_stage u_gates (
		.clk_sys_i  (clk_sys_i),
		.rst_b_i    (rst_b_i),
		.ce_i       (ce_i),
		.force_i    (force_gates),
		.pwm_gate_i (pwm_gate),
		.level_i    (gate_protect_level_select),
		.gate_o     (gate_bus)
	);

	assign phase_a_high_gate_o = gate_bus[`OCP_LVL_A_HIGH]; // R8
	assign phase_a_low_gate_o  = gate_bus[`OCP_LVL_A_LOW]; // R8
	assign phase_b_high_gate_o = gate_bus[`OCP_LVL_B_HIGH]; // R7
	assign phase_b_low_gate_o  = gate_bus[`OCP_LVL_B_LOW]; // R7
	assign phase_c_high_gate_o = gate_bus[`OCP_LVL_C_HIGH]; // R6
	assign phase_c_low_gate_o  = gate_bus[`OCP_LVL_C_LOW]; // R6

	// forced indication lines up with the gate pins
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			outputs_forced_o <= 1'b0;
		end else if (ce_i) begin
			outputs_forced_o <= force_gates;
		end
	end

	// ======================================================================
	// register read

	assign status_word = {2'b00,
	                      fault_seen,
	                      trip_seen,
	                      trip_sync,
	                      fault_latched,
	                      cbc_cut,
	                      outputs_forced_o};

	// read data only in the cycle after the strobe; unmapped reads zero
	always @* begin
		next_rdata = 8'h00;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`OCP_OFS_CONTROL: begin
					next_rdata[`OCP_CTL_CBC_ENABLE]   = cycle_by_cycle_enable;
					next_rdata[`OCP_CTL_SW_PAUSE_SEL] = sw_pause_fault_select;
					next_rdata[`OCP_CTL_SW_REQUEST]   = sw_protect_request;
				end
				`OCP_OFS_LEVEL_SEL: begin
					next_rdata = {2'b00, gate_protect_level_select}; // R9
				end
				`OCP_OFS_STATUS: begin
					next_rdata = status_word;
				end
				`OCP_OFS_TRIP_COUNT: begin
					next_rdata = trip_count;
				end
				`OCP_OFS_CUT_PERIODS: begin
					next_rdata = cut_periods;
				end
				default: begin
					next_rdata = 8'h00;
				end
			endcase
		end
	end

	// read data register
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 8'h00;
		end else if (ce_i) begin
			reg_rdata_o <= next_rdata;
		end
	end

endmodule // pwm_overcurrent_protection

`default_nettype wire

/* tb/gate_bridge_model.sv */
`default_nettype none

// ==========================================================================
// bridge stand-in: over current only flows while a high side conducts
module gate_bridge_model (
	input  wire logic [5:0] gate_i,
	input  wire logic       overload_i,
	output logic            trip_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// comparator lags the bridge, so the trip is not aligned to the clock
	assign #2 trip_o = overload_i && (gate_i[0] || gate_i[2] || gate_i[4]);
endmodule // gate_bridge_model

`default_nettype wire

/* tb/ocp_checker_sva.sv */
`default_nettype none
`include "ocp_defs.vh"

// ==========================================================================
// protection checker, sees the top ports only
module ocp_checker (
	input wire logic       clk_sys_i,
	input wire logic       rst_b_i,
	input wire logic       ce_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       pwm_period_start_i,
	input wire logic       current_sense_trip_i,
	input wire logic       phase_a_high_gate_o,
	input wire logic       phase_a_low_gate_o,
	input wire logic       phase_b_high_gate_o,
	input wire logic       phase_b_low_gate_o,
	input wire logic       phase_c_high_gate_o,
	input wire logic       phase_c_low_gate_o,
	input wire logic       outputs_forced_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] ctl;
	logic [5:0] lvl;
	logic       flt;
	wire  [5:0] gates = {phase_c_low_gate_o, phase_c_high_gate_o, phase_b_low_gate_o,
		phase_b_high_gate_o, phase_a_low_gate_o, phase_a_high_gate_o};
	wire        rd0 = ce_i && reg_rd_i && reg_addr_i == `OCP_OFS_CONTROL;
	wire        rd1 = ce_i && reg_rd_i && reg_addr_i == `OCP_OFS_LEVEL_SEL;
	wire        quiet = !ctl[0] && !flt;
	wire        cbc = ce_i && ctl[6] && current_sense_trip_i;
	// a control write on the period edge may raise a pause request at once
	wire        wr0 = ce_i && reg_wr_i && reg_addr_i == `OCP_OFS_CONTROL;

	// shadow of written registers; the fault flag lets restore checks skip a latched fault
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctl <= 8'h00;
			lvl <= 6'h00;
			flt <= 1'b0;
		end else if (ce_i && reg_wr_i) begin
			if (reg_addr_i == `OCP_OFS_CONTROL) begin
				ctl <= reg_wdata_i;
				if (reg_wdata_i[0] && !reg_wdata_i[4] && !ctl[0])
					flt <= 1'b1;
			end
			if (reg_addr_i == `OCP_OFS_LEVEL_SEL)
				lvl <= reg_wdata_i[5:0];
			if (reg_addr_i == `OCP_OFS_STATUS && reg_wdata_i[2])
				flt <= 1'b0;
		end
	end

	// ==========================================================================
	// properties
	default clocking dc @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	property p_rdata_idle;
		$past(ce_i) && !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	property p_lvl_readback;
		$past(rd1) |-> reg_rdata_o == {2'b00, $past(lvl)};
	endproperty
	a_lvl_readback: assert property (p_lvl_readback) else $error("level readback");
	property p_ctl_readback;
		$past(rd0) |-> reg_rdata_o == ($past(ctl) & 8'h51);
	endproperty
	a_ctl_readback: assert property (p_ctl_readback) else $error("control readback");
	property p_forced_level;
		$past(ce_i) && outputs_forced_o |-> gates == $past(lvl);
	endproperty
	a_forced_level: assert property (p_forced_level) else $error("forced level");
	property p_cbc_cut;
		cbc [*4] |=> outputs_forced_o;
	endproperty
	a_cbc_cut: assert property (p_cbc_cut) else $error("trip not cut");
	property p_cbc_persist;
		cbc [*5] ##0 pwm_period_start_i |=> ##1 outputs_forced_o;
	endproperty
	a_cbc_persist: assert property (p_cbc_persist) else $error("cut dropped");
	property p_cbc_restore;
		(ce_i && quiet && !current_sense_trip_i) [*4] ##0 (pwm_period_start_i && !wr0)
			|=> ##1 !outputs_forced_o;
	endproperty
	a_cbc_restore: assert property (p_cbc_restore) else $error("no restore");
	property p_pause_force;
		ce_i && reg_wr_i && reg_addr_i == `OCP_OFS_CONTROL && reg_wdata_i[4] && reg_wdata_i[0]
			|=> ##1 outputs_forced_o;
	endproperty
	a_pause_force: assert property (p_pause_force) else $error("pause not forced");
	c_cut: cover property (outputs_forced_o && ctl[6]);
	c_fault: cover property (outputs_forced_o && flt);
	c_restore: cover property ($fell(outputs_forced_o));
endmodule // ocp_checker

bind pwm_overcurrent_protection ocp_checker ocp_checker_i (
	.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .pwm_period_start_i(pwm_period_start_i),
	.current_sense_trip_i(current_sense_trip_i), .phase_a_high_gate_o(phase_a_high_gate_o),
	.phase_a_low_gate_o(phase_a_low_gate_o), .phase_b_high_gate_o(phase_b_high_gate_o),
	.phase_b_low_gate_o(phase_b_low_gate_o), .phase_c_high_gate_o(phase_c_high_gate_o),
	.phase_c_low_gate_o(phase_c_low_gate_o), .outputs_forced_o(outputs_forced_o));

`default_nettype wire

/* tb/tb_pwm_overcurrent_protection.sv */
`default_nettype none
`include "ocp_defs.vh"

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end

module tb_pwm_overcurrent_protection;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk, rst_b, ce, wr, rd, period, overload;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [5:0] pwm;
	wire  [7:0] rdata;
	wire  [5:0] gate;
	wire        forced, trip;
	int         fail_count, n_compared;

	pwm_overcurrent_protection pwm_overcurrent_protection_i (
		.clk_sys_i(clk), .rst_b_i(rst_b), .ce_i(ce), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .pwm_period_start_i(period),
		.phase_a_high_pwm_i(pwm[0]), .phase_a_low_pwm_i(pwm[1]), .phase_b_high_pwm_i(pwm[2]),
		.phase_b_low_pwm_i(pwm[3]), .phase_c_high_pwm_i(pwm[4]), .phase_c_low_pwm_i(pwm[5]),
		.current_sense_trip_i(trip), .phase_a_high_gate_o(gate[0]),
		.phase_a_low_gate_o(gate[1]), .phase_b_high_gate_o(gate[2]),
		.phase_b_low_gate_o(gate[3]), .phase_c_high_gate_o(gate[4]),
		.phase_c_low_gate_o(gate[5]), .outputs_forced_o(forced));
	gate_bridge_model gate_bridge_model_i (.gate_i(gate), .overload_i(overload), .trip_o(trip));

	// ==========================================================================
	// clock and bus tasks
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK("rdata", e, rdata)
	endtask
	task automatic pulse();
		@(posedge clk);
		period <= 1'b1;
		@(posedge clk);
		period <= 1'b0;
	endtask
	// bounded wait; a miss ends the run at once
	task automatic wait_forced(input logic v);
		for (int i = 0; i < 12; i++) begin
			#1;
			if (forced === v)
				break;
			@(posedge clk);
		end
		`CHK("forced", v, forced)
		if (forced !== v)
			results();
	endtask
	task automatic results();
		if (fail_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================================================
	// main sequence
	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		period = 1'b0;
		overload = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		pwm = 6'h2d;
		fail_count = 0;
		n_compared = 0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		// reset values, an unmapped place, each level bit alone
		rd_chk(`OCP_OFS_CONTROL, 8'h00);
		rd_chk(`OCP_OFS_LEVEL_SEL, 8'h00);
		rd_chk(4'hf, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr_reg(`OCP_OFS_LEVEL_SEL, 8'(1 << i));
			rd_chk(`OCP_OFS_LEVEL_SEL, 8'(1 << i));
		end
		wr_reg(`OCP_OFS_LEVEL_SEL, 8'hff);
		rd_chk(`OCP_OFS_LEVEL_SEL, 8'h3f);
		wr_reg(`OCP_OFS_CONTROL, 8'h50);
		rd_chk(`OCP_OFS_CONTROL, 8'h50);
		// pause mode: each gate takes its own level while forced
		wr_reg(`OCP_OFS_CONTROL, 8'h11);
		wait_forced(1'b1);
		for (int i = 0; i < 6; i++) begin
			wr_reg(`OCP_OFS_LEVEL_SEL, 8'(1 << i));
			cyc(1);
			`CHK("gates", 6'(1 << i), gate)
		end
		wr_reg(`OCP_OFS_CONTROL, 8'h10);
		wait_forced(1'b0);
		cyc(1);
		`CHK("gates", pwm, gate)
		// fault mode holds after the request drops, until released
		wr_reg(`OCP_OFS_CONTROL, 8'h01);
		wait_forced(1'b1);
		wr_reg(`OCP_OFS_CONTROL, 8'h00);
		cyc(4);
		`CHK("forced", 1'b1, forced)
		wr_reg(`OCP_OFS_STATUS, 8'h04);
		wait_forced(1'b0);
		// cycle-by-cycle: low levels starve the trip, the next period restores
		wr_reg(`OCP_OFS_LEVEL_SEL, 8'h00);
		pwm <= 6'h15;
		wr_reg(`OCP_OFS_CONTROL, 8'h40);
		overload <= 1'b1;
		wait_forced(1'b1);
		cyc(6);
		`CHK("gates", 6'h00, gate)
		pulse();
		wait_forced(1'b0);
		wait_forced(1'b1);
		// a trip that outlives the period keeps the cut
		wr_reg(`OCP_OFS_LEVEL_SEL, 8'h15);
		cyc(6);
		pulse();
		cyc(3);
		`CHK("forced", 1'b1, forced)
		`CHK("gates", 6'h15, gate)
		@(posedge clk);
		overload <= 1'b0;
		cyc(6);
		pulse();
		wait_forced(1'b0);
		// with the cut disabled a trip leaves the gates alone
		wr_reg(`OCP_OFS_CONTROL, 8'h00);
		overload <= 1'b1;
		cyc(10);
		`CHK("forced", 1'b0, forced)
		`CHK("gates", 6'h15, gate)
		// event record: four synchronised trip rises, one period held through the cut
		rd_chk(`OCP_OFS_TRIP_COUNT, 8'h04);
		rd_chk(`OCP_OFS_CUT_PERIODS, 8'h01);
		rd_chk(`OCP_OFS_STATUS, 8'h38);
		wr_reg(`OCP_OFS_STATUS, 8'h30);
		rd_chk(`OCP_OFS_STATUS, 8'h08);
		wr_reg(`OCP_OFS_TRIP_COUNT, 8'h00);
		rd_chk(`OCP_OFS_TRIP_COUNT, 8'h00);
		// a low clock enable must swallow a write
		@(posedge clk);
		ce <= 1'b0;
		wr_reg(`OCP_OFS_LEVEL_SEL, 8'h2a);
		ce <= 1'b1;
		rd_chk(`OCP_OFS_LEVEL_SEL, 8'h15);
		results();
	end
endmodule // tb_pwm_overcurrent_protection

`default_nettype wire
